/* dv/phs_hw_model.sv */
// phs_hw_model: far side of the highway: clock, frame sync, receive data
// assumes: frame sync line pulled low when nobody drives it
module phs_hw_model (
    output logic hw_clk, // bit clock
    input wire logic master, // device owns sync
    input wire logic fs_dev, // device sync
    input wire logic fs_dev_oe, // device sync enable
    output logic frame_sync, // sync line
    input wire logic [5:0] slot, // device slot
    input wire logic [7:0] rx_pat, // byte to send
    input wire logic tx_out, // device tx
    input wire logic tx_oe, // device tx enable
    output logic rx_in, // receive line
    output logic [7:0] tx_cap // byte taken from tx
);
    timeunit 1ns;
    timeprecision 1ps;
    int cyc = 0;
    int cnt = 99;
    logic fs_own = 1'b0;
    // the port counts bit 0 from the fall after the one that saw sync
    wire in_slot = cnt >= slot * 8 + 1 && cnt < slot * 8 + 9;
    initial hw_clk = 1'b0;
    initial rx_in = 1'b0;
    always #40 hw_clk = ~hw_clk;
    always @(posedge hw_clk) begin
        cyc <= (cyc + 1) % 40;
        fs_own <= cyc == 39;
    end
    assign frame_sync = master ? fs_dev_oe & fs_dev : fs_own;
    always @(negedge hw_clk) begin
        cnt <= frame_sync ? 0 : cnt + 1;
        if (in_slot) tx_cap <= {tx_cap[6:0], tx_oe ? tx_out : 1'bx};
    end
    // new bit a little after the rise, so only a falling-edge sample sees it
    always @(posedge hw_clk) #10 rx_in = in_slot ? rx_pat[8 - (cnt - slot * 8)] : ~rx_in;
endmodule : phs_hw_model

/* dv/phs_slot_port_monitor.sv */
// phs_slot_port_monitor: pin timing checks on the highway slot port
// assumes: bound into phs_slot_port; checks run on the highway clock
module phs_slot_port_monitor (
    input wire logic nrst, // reset
    input wire logic hw_clk, // bit clock
    input wire logic frame_sync_out, // sync out
    input wire logic tx_out, // tx level
    input wire logic tx_oe, // tx enable
    input wire logic tx_weak, // tx weak
    input wire logic slot_active_out, // slot level
    input wire logic slot_active_oe // slot pull low
);
    default clocking cb @(posedge hw_clk); endclocking
    default disable iff (!nrst);
    logic tx_at_fall;
    // mid-bit level, compared with the level just before the next rise
    always_ff @(negedge hw_clk or negedge nrst)
        if (!nrst) tx_at_fall <= 1'b0;
        else tx_at_fall <= tx_out;
    a_strong_then_weak: assert property (
        $rose(tx_oe) |-> (tx_oe && !tx_weak) [*7] ##1 (tx_oe && tx_weak)) else $error("bad drive strength");
    a_weak_holds: assert property (tx_weak |-> tx_oe) else $error("weak undriven");
    a_tx_release: assert property (tx_weak |=> !tx_oe && !tx_weak) else $error("tx held");
    a_tx_on_rise: assert property (tx_oe |-> tx_out == tx_at_fall) else $error("tx moved at fall");
    a_sa_low_only: assert property (!slot_active_out) else $error("slot line high");
    a_sa_in_slot: assert property ($rose(tx_oe) |-> slot_active_oe) else $error("slot line idle");
    a_sa_release: assert property (tx_weak |-> !slot_active_oe) else $error("slot line late");
    a_sync_period: assert property (
        $rose(frame_sync_out) |=> !frame_sync_out ##63 frame_sync_out) else $error("bad sync period");
endmodule : phs_slot_port_monitor
bind phs_slot_port phs_slot_port_monitor i_mon (.nrst, .hw_clk, .frame_sync_out, .tx_out, .tx_oe, .tx_weak,
    .slot_active_out, .slot_active_oe);

/* dv/tb.sv */
// tb: highway slot port against the highway partner model
// assumes: partner makes the bit clock and, in slave mode, frame sync
module tb;
    import phs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; \
        $display("wrong value at %0t: %0h expected %0h", $time, a, e); end end
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    phs_cfg_t cfg = '0;
    logic [7:0] tx_data = 8'h00, rx_pat = 8'h00, tx_cap;
    phs_byte_t rx_byte;
    logic hw_clk, tx_done, fs, fs_out, fs_oe, tx_out, tx_oe, tx_weak, rx_in, sa_out, sa_oe;
    logic drove = 1'b0;
    int err_count = 0, check_count = 0, cycles = 0, done_n = 0;
    phs_slot_port i_phs_slot_port (.ref_clk, .nrst, .hw_clk, .cfg, .tx_data, .rx_byte, .tx_done,
        .frame_sync_in(fs), .frame_sync_out(fs_out), .frame_sync_oe(fs_oe), .tx_out, .tx_oe, .tx_weak,
        .rx_in, .slot_active_out(sa_out), .slot_active_oe(sa_oe));
    phs_hw_model i_phs_hw_model (.hw_clk, .master(cfg.master), .fs_dev(fs_out), .fs_dev_oe(fs_oe),
        .frame_sync(fs), .slot(cfg.slot), .rx_pat, .tx_out, .tx_oe, .rx_in, .tx_cap);
    always #5 ref_clk = ~ref_clk;
    always @(posedge hw_clk) if (tx_oe || sa_oe) drove = 1'b1;
    always @(posedge ref_clk) begin
        if (tx_done === 1'b1) done_n <= done_n + 1;
        cycles++;
        if (cycles == 40000) begin
            err_count++;
            test_done();
        end
    end
    task automatic wait_valid();
        int n = 0;
        while (rx_byte.valid !== 1'b1 && n < 2000) begin
            @(posedge ref_clk);
            n++;
        end
        `CHK(n < 2000, 1'b1)
        @(posedge ref_clk);
    endtask : wait_valid
    task automatic run_slot(input logic m, input logic [5:0] s, input logic [7:0] t, input logic [7:0] r);
        int d0;
        @(posedge ref_clk);
        cfg <= '{master: m, slot: s, enable: 1'b1};
        tx_data <= t;
        rx_pat <= r;
        wait_valid();
        wait_valid();
        d0 = done_n;
        wait_valid();
        `CHK(rx_byte.data, r)
        `CHK(tx_cap, t)
        `CHK(done_n - d0, 1)
    endtask : run_slot
    task automatic t_off(input logic [5:0] s, input logic en);
        @(posedge ref_clk);
        cfg <= '{master: 1'b0, slot: s, enable: en};
        repeat (400) @(posedge ref_clk);
        drove = 1'b0;
        repeat (600) @(posedge ref_clk);
        `CHK(drove, 1'b0)
    endtask : t_off
    task automatic t_master();
        run_slot(1'b1, 6'h02, 8'h96, 8'h5A);
        @(posedge fs_out);
        @(negedge hw_clk);
        `CHK(fs_out, 1'b1)
        @(negedge hw_clk);
        `CHK(fs_out, 1'b0)
        repeat (62) @(negedge hw_clk);
        `CHK(fs_out, 1'b0)
        @(negedge hw_clk);
        `CHK({fs_out, fs_oe}, 2'h3)
    endtask : t_master
    task automatic test_done();
        if (err_count == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done
    initial begin
        repeat (12) @(posedge ref_clk);
        nrst <= 1'b1;
        for (int s = 0; s < 4; s++) run_slot(1'b0, 6'(s), 8'hA5 ^ 8'(s), 8'h3C + 8'(s));
        t_off(6'h01, 1'b0);
        t_off(6'h21, 1'b1);
        t_master();
        test_done();
    end
endmodule : tb

/* rtl/phs_consts.svh */
// phs_consts.svh: offsets, positions and counts for the highway slot port
// assumes: included by bare name in the package only; design files use its macros from there
`ifndef PHS_CONSTS_SVH
`define PHS_CONSTS_SVH
`define PHS_FRAME_W 8
`define PHS_SLOT_W 6
`define PHS_BYTE_W 8
`define PHS_FS_MIN_PERIOD 8'h10
`define PHS_FS_MIN_LOW 8'h08
`define PHS_MASTER_FRAME 8'h40
`define PHS_MASTER_FS_HI 8'h01
`endif

/* rtl/phs_pkg.sv */
// phs_pkg: types shared by the highway slot port
// assumes: phs_consts.svh on the include path
`include "phs_consts.svh"
package phs_pkg;
    typedef struct packed {
        logic master;
        logic [`PHS_SLOT_W-1:0] slot;
        logic enable;
    } phs_cfg_t;
    typedef struct packed {
        logic valid;
        logic [`PHS_BYTE_W-1:0] data;
    } phs_byte_t;
    typedef enum logic [1:0] {TX_IDLE, TX_DRIVE, TX_WEAK} phs_tx_state_t;
endpackage : phs_pkg

/* rtl/phs_slot_port.sv */
// phs_slot_port: one-byte time-slot port on a shared serial highway
// assumes: hw_clk is the highway bit clock; user side on ref_clk; pad logic resolves oe/weak
// Behaviour
// - first half of last bit driven strongly
// - second half of last bit weak hold
// - release transmit line after weak half
// - slot active output is open drain
// - slot active from slot start to last fall
// - transmit data changes on rising edges
// - first bit after later of edge, sync
// - receive data sampled on falling edges
// - slave detects high sync on falling edge
// - master drives sync on rising edges
module phs_slot_port
    import phs_pkg::*;
(
    input wire logic ref_clk, // system clock 100 MHz
    input wire logic nrst, // async reset, active low
    input wire logic hw_clk, // highway bit clock
    input wire phs_cfg_t cfg, // static configuration, ref_clk domain
    input wire logic [`PHS_BYTE_W-1:0] tx_data, // byte to send, held stable
    output phs_byte_t rx_byte, // received byte, valid one cycle
    output logic tx_done, // pulse when the slot's last bit is launched
    input wire logic frame_sync_in, // frame sync pin input
    output logic frame_sync_out, // frame sync pin output
    output logic frame_sync_oe, // frame sync drive enable (master)
    output logic tx_out, // transmit line level
    output logic tx_oe, // transmit line drive enable
    output logic tx_weak, // transmit line drive is weak
    input wire logic rx_in, // receive line
    output logic slot_active_out, // slot active pin output, always low
    output logic slot_active_oe // slot active open drain enable
);
    // link-domain copies of configuration
    logic [$bits(phs_cfg_t)-1:0] cfg_l_raw;
    phs_cfg_t cfg_l;
    phs_sync #(.W($bits(phs_cfg_t))) u_cfg_sync (
        .clk(hw_clk),
        .nrst(nrst),
        .d(cfg),
        .q(cfg_l_raw)
    );
    assign cfg_l = phs_cfg_t'(cfg_l_raw);

    // tx byte handed over by a two-flop level synchroniser: sampled at each frame start
    logic [`PHS_BYTE_W-1:0] tx_hold;
    logic [`PHS_BYTE_W-1:0] tx_hold_l;

    // frame sync: slave samples pin on falling edge, master generates on rising edge
    logic fs_fall;
    logic fs_fall_d;
    logic [`PHS_FRAME_W-1:0] mcnt;
    logic fs_master;
    always_ff @(negedge hw_clk or negedge nrst) begin
        if (!nrst) begin
            fs_fall <= 1'b0;
            fs_fall_d <= 1'b0;
        end else begin
            fs_fall <= frame_sync_in;
            fs_fall_d <= fs_fall;
        end
    end
    wire logic [`PHS_FRAME_W-1:0] next_mcnt =
        (mcnt == `PHS_MASTER_FRAME - 8'h01) ? 8'h00 : mcnt + 8'h01;
    always_ff @(posedge hw_clk or negedge nrst) begin
        if (!nrst) begin
            mcnt <= 8'h00;
            fs_master <= 1'b0;
        end else begin
            mcnt <= next_mcnt;
            fs_master <= cfg_l.enable && cfg_l.master && (next_mcnt < `PHS_MASTER_FS_HI);
        end
    end
    assign frame_sync_out = fs_master;
    assign frame_sync_oe = cfg_l.master;

    // frame start seen on falling edge: slave from pin, master from own sync
    logic fs_master_n;
    logic fs_master_nd;
    always_ff @(negedge hw_clk or negedge nrst) begin
        if (!nrst) begin
            fs_master_n <= 1'b0;
            fs_master_nd <= 1'b0;
        end else begin
            fs_master_n <= fs_master;
            fs_master_nd <= fs_master_n;
        end
    end
    wire logic frame_start = cfg_l.master ? (fs_master_n && !fs_master_nd) : (fs_fall && !fs_fall_d);

    // bit counter within the frame, on falling edges
    logic [`PHS_FRAME_W-1:0] bcnt;
    logic counting;
    always_ff @(negedge hw_clk or negedge nrst) begin
        if (!nrst) begin
            bcnt <= 8'h00;
            counting <= 1'b0;
        end else if (frame_start) begin
            bcnt <= 8'h00;
            counting <= cfg_l.enable;
        end else if (counting) begin
            bcnt <= (bcnt == 8'hFF) ? bcnt : bcnt + 8'h01;
        end
    end
    wire logic [`PHS_FRAME_W-1:0] slot_first = {cfg_l.slot[4:0], 3'b000};
    wire logic in_slot = counting && (bcnt >= slot_first)
        && (bcnt < slot_first + 8'h08) && !cfg_l.slot[5];
    wire logic [2:0] bit_idx = 3'(bcnt - slot_first);
    wire logic last_bit = in_slot && (bit_idx == 3'h7);
    // a bit cell runs from rising edge to next rising edge; slot begins at the
    // rising edge after the falling edge that opened it, which follows sync
    // so data never leads the later of clock edge and frame sync

    // registered slot position, launched on rising edges, read at the falling edge mid-cell
    logic in_slot_r;
    logic [2:0] bit_idx_r;

    // receive: shift on falling edges inside the slot
    logic [`PHS_BYTE_W-1:0] rx_shift;
    logic rx_tog;
    logic [`PHS_BYTE_W-1:0] rx_word;
    always_ff @(negedge hw_clk or negedge nrst) begin
        if (!nrst) begin
            rx_shift <= 8'h00;
            rx_word <= 8'h00;
            rx_tog <= 1'b0;
        end else if (in_slot_r) begin
            rx_shift <= {rx_shift[6:0], rx_in};
            if (bit_idx_r == 3'h7) begin
                rx_word <= {rx_shift[6:0], rx_in};
                rx_tog <= ~rx_tog;
            end
        end
    end

    // transmit: drive on rising edges, weak on falling edge of last bit
    logic [`PHS_BYTE_W-1:0] tx_shift;
    logic tx_drive;
    logic tx_tog;
    always_ff @(posedge hw_clk or negedge nrst) begin
        if (!nrst) begin
            in_slot_r <= 1'b0;
            bit_idx_r <= 3'h0;
            tx_shift <= 8'h00;
            tx_drive <= 1'b0;
            tx_tog <= 1'b0;
        end else begin
            in_slot_r <= in_slot;
            bit_idx_r <= bit_idx;
            tx_drive <= in_slot;
            if (in_slot && bit_idx == 3'h0) begin
                tx_shift <= tx_hold_l;
            end else if (in_slot) begin
                tx_shift <= {tx_shift[6:0], 1'b0};
            end
            if (in_slot && bit_idx == 3'h7) begin
                tx_tog <= ~tx_tog;
            end
        end
    end
    logic weak_half;
    always_ff @(negedge hw_clk or negedge nrst) begin
        if (!nrst) begin
            weak_half <= 1'b0;
        end else begin
            weak_half <= in_slot_r && (bit_idx_r == 3'h7);
        end
    end
    // falling edge of last bit turns to weak; following rising edge clears drive
    assign tx_out = tx_shift[7];
    // drive stays on through the weak half and drops at the rising edge after it
    assign tx_oe = tx_drive;
    assign tx_weak = tx_drive && weak_half;
    // slot active: low pulled while in slot, released at last bit falling edge
    assign slot_active_out = 1'b0;
    assign slot_active_oe = tx_drive && !weak_half;

    // tx byte crosses to link domain: sampled each frame start
    always_ff @(negedge hw_clk or negedge nrst) begin
        if (!nrst) begin
            tx_hold_l <= 8'h00;
        end else if (frame_start) begin
            tx_hold_l <= tx_hold;
        end
    end
    // the byte comes from the ref_clk side, so it passes two link-clock flops first
    phs_sync #(.W(`PHS_BYTE_W)) u_tx_sync (
        .clk(hw_clk),
        .nrst(nrst),
        .d(tx_data),
        .q(tx_hold)
    );

    // events back to ref_clk by toggle synchronisers
    logic [1:0] tog_s;
    logic [1:0] tog_d;
    phs_sync #(.W(2)) u_tog_sync (
        .clk(ref_clk),
        .nrst(nrst),
        .d({rx_tog, tx_tog}),
        .q(tog_s)
    );
    wire logic rx_evt = tog_s[1] ^ tog_d[1];
    wire logic tx_evt = tog_s[0] ^ tog_d[0];
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            tog_d <= 2'b00;
            rx_byte <= '0;
            tx_done <= 1'b0;
        end else begin
            tog_d <= tog_s;
            rx_byte.valid <= rx_evt;
            if (rx_evt) begin
                rx_byte.data <= rx_word;
            end
            tx_done <= tx_evt;
        end
    end
endmodule : phs_slot_port

/* rtl/phs_sync.sv */
// phs_sync: two-flop level synchroniser
// assumes: d is asynchronous to clk
module phs_sync #(parameter int W = 1) (
    input wire logic clk, // destination clock
    input wire logic nrst, // async reset, active low
    input wire logic [W-1:0] d, // asynchronous level
    output logic [W-1:0] q // synchronised level
);
    logic [W-1:0] meta;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : phs_sync
